// ### pmu_regs_pkg.sv
package pmu_regs_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_OVERLOAD_IRQ_ENABLE_2 = 8'h03; // Second interrupt-enable register
    localparam logic [7:0] OFS_CHARGER_CONTROL_0     = 8'h04; // First charger control
    localparam logic [7:0] OFS_CHARGER_CONTROL_1     = 8'h05; // Second charger control

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_OVERLOAD_IRQ_ENABLE_2 = 8'h00; // All overload irqs disabled
    localparam logic [7:0] RST_CHARGER_CONTROL_0     = 8'h02; // Pin gate on, charger off
    localparam logic [7:0] RST_CHARGER_CONTROL_1     = 8'h20; // Cold threshold code 001

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BUCK3_ENABLE_BIT  = 0;  // Enable for third step-down converter
    localparam int SWITCH1_ENABLE_BIT = 1; // Lowest load-switch enable bit
    localparam int OVERLOAD_CHANNELS = 8;  // Seven switches plus buck three

    // ----------------------------------------------------------------
    // Bus framing constants
    // ----------------------------------------------------------------
    localparam logic [3:0] BYTE_BITS = 4'h8; // Bits per I2C byte
    localparam logic [6:0] DEFAULT_TARGET_ADDR = 7'h2A; // Arbitrary value, set by strap parameter

    // ----------------------------------------------------------------
    // Field layouts
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       reserved;               // Reads zero, writes dropped
        logic       battery_current_derate; // 1 selects 90 percent
        logic       adapter_current_derate; // 1 selects 90 percent
        logic [2:0] fast_charge_timeout_sel; // Safety timer code
        logic       ext_charge_pin_gate;    // 1 lets the pin control charging
        logic       charger_on;             // 1 enables the charger
    } charger_control_0_t;

    typedef struct packed {
        logic [2:0] cold_threshold_sel;        // Threshold code
        logic [1:0] cold_range_term_voltage;   // Feedback voltage code
        logic [2:0] cold_range_charge_current; // Current scale code
    } charger_control_1_t;

    // Byte role while receiving
    typedef enum logic [2:0] {
        KIND_ADDR = 3'b001, // Target address plus direction
        KIND_PTR  = 3'b010, // Register pointer
        KIND_DATA = 3'b100  // Write data
    } byte_kind_t;

    // Target state machine
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001, // Waiting for a start
        ST_RECV = 5'b00010, // Shifting a byte in
        ST_ACK  = 5'b00100, // Driving our acknowledge
        ST_SEND = 5'b01000, // Shifting a byte out
        ST_MACK = 5'b10000  // Sampling the master acknowledge
    } i2c_state_t;

    // Safety timer code to whole hours; code 011 taken as five
    function automatic logic [3:0] timeout_hours(input logic [2:0] code);
        logic [3:0] h;
        h = 4'h0;
        case (code)
            3'h0:    h = 4'h2;
            3'h1:    h = 4'h3;
            3'h2:    h = 4'h4;
            3'h3:    h = 4'h5;
            3'h4:    h = 4'h6;
            3'h5:    h = 4'h7;
            3'h6:    h = 4'h8;
            default: h = 4'hA;
        endcase
        return h;
    endfunction

endpackage

// ### overload_flag_bank.sv
module overload_flag_bank #(
    parameter int WIDTH = 8                  // Number of overload channels
) (
    input  wire logic             i_clk,      // System clock
    input  wire logic             i_reset,    // Synchronous reset, high
    input  wire logic [WIDTH-1:0] i_overload, // Raw overload levels
    input  wire logic [WIDTH-1:0] i_enable,   // Per-channel irq enables
    input  wire logic             i_clear,    // Host interrupt clear
    output logic      [WIDTH-1:0] o_flags,    // Sticky overload flags
    output logic                  o_irq_req   // One-cycle interrupt request
);

    logic [WIDTH-1:0] level_q; // Previous overload levels
    logic [WIDTH-1:0] flag_q;  // Sticky flags
    logic             req_q;   // Registered request pulse
    logic [WIDTH-1:0] rise;    // Rising edges this cycle

    assign rise = i_overload & ~level_q;

    // ----------------------------------------------------------------
    // Edge history
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            level_q <= '0;
        end else begin
            level_q <= i_overload;
        end
    end

    // Flags: a new rise beats a clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            flag_q <= '0;
        end else if (i_clear) begin
            flag_q <= rise;
        end else begin
            flag_q <= flag_q | rise;
        end
    end

    // Request only for enabled channels
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            req_q <= 1'b0;
        end else begin
            req_q <= |(rise & i_enable);
        end
    end

    assign o_flags   = flag_q;
    assign o_irq_req = req_q;

endmodule

// ### pmu_irq_mask_charger_ctrl_regs.sv
module pmu_irq_mask_charger_ctrl_regs #(
    parameter logic [6:0] TARGET_ADDR = pmu_regs_pkg::DEFAULT_TARGET_ADDR // Bus address
) (
    input  wire logic       i_clk,                     // System clock, 125 MHz
    input  wire logic       i_reset,                   // Synchronous reset, high
    input  wire logic       i_scl,                     // I2C clock level
    input  wire logic       i_sda,                     // I2C data level
    output logic            o_sda,                     // I2C data drive value, always low
    output logic            o_sda_oe,                  // High while pulling data low
    input  wire logic [7:1] i_switch_overload,         // Load-switch overload levels
    input  wire logic       i_buck3_overload,          // Buck three overload level
    input  wire logic       i_irq_clear,               // Interrupt clear strobe
    output logic      [7:0] o_overload_flags,          // Sticky overload flags
    output logic            o_overload_irq_req,        // Interrupt request pulse
    output logic      [7:0] o_overload_irq_enable,     // Enable register image
    output pmu_regs_pkg::charger_control_0_t o_charger_control_0, // Charger control
    output pmu_regs_pkg::charger_control_1_t o_charger_control_1, // Cold range setup
    output logic      [3:0] o_fast_charge_hours        // Decoded safety timeout
);
    import pmu_regs_pkg::*;

    // ----------------------------------------------------------------
    // Pin history and bus conditions
    // ----------------------------------------------------------------
    logic       scl_q;      // Previous clock level
    logic       sda_q;      // Previous data level
    logic       scl_rise;   // Clock rising
    logic       scl_fall;   // Clock falling
    logic       bus_start;  // Start or repeated start
    logic       bus_stop;   // Stop condition

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= i_scl;
            sda_q <= i_sda;
        end
    end

    assign scl_rise  = i_scl & ~scl_q;
    assign scl_fall  = ~i_scl & scl_q;
    assign bus_start = i_scl & scl_q & sda_q & ~i_sda;
    assign bus_stop  = i_scl & scl_q & ~sda_q & i_sda;

    // ----------------------------------------------------------------
    // Target state
    // ----------------------------------------------------------------
    i2c_state_t state_q;    // Protocol state
    byte_kind_t kind_q;     // Role of byte being received
    logic [3:0] cnt_q;      // Bits done in current byte
    logic [7:0] shift_q;    // Receive shift register
    logic [7:0] tx_q;       // Transmit shift register
    logic [7:0] ptr_q;      // Register pointer, auto-increments
    logic       read_q;     // Transfer direction is read
    logic       mack_q;     // Master acknowledged last byte
    logic       oe_q;       // Data pull-down
    logic [7:0] rd_data;    // Read mux output
    logic       byte_done;  // Eighth bit finished, clock falling
    logic       addr_hit;   // Address byte names us
    logic       wr_fire;    // Data byte completes a write

    // Registers
    logic [7:0]         irq_enable_q; // Overload irq enables
    charger_control_0_t ctrl0_q;      // First charger control
    charger_control_1_t ctrl1_q;      // Second charger control

    assign byte_done = (state_q == ST_RECV) && scl_fall && (cnt_q == BYTE_BITS);
    assign addr_hit  = (shift_q[7:1] == TARGET_ADDR);
    assign wr_fire   = byte_done && (kind_q == KIND_DATA);

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_data = 8'h00;
        if (ptr_q == OFS_OVERLOAD_IRQ_ENABLE_2) begin
            rd_data = irq_enable_q;
        end else if (ptr_q == OFS_CHARGER_CONTROL_0) begin
            rd_data = {1'b0, ctrl0_q[6:0]};
        end else if (ptr_q == OFS_CHARGER_CONTROL_1) begin
            rd_data = ctrl1_q;
        end else begin
            rd_data = 8'h00;
        end
    end

    // Protocol sequencer; start and stop override any state
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_q <= ST_IDLE;
            kind_q  <= KIND_ADDR;
            cnt_q   <= 4'h0;
            shift_q <= 8'h00;
            tx_q    <= 8'h00;
            read_q  <= 1'b0;
            mack_q  <= 1'b0;
            oe_q    <= 1'b0;
        end else if (bus_start) begin
            state_q <= ST_RECV;
            kind_q  <= KIND_ADDR;
            cnt_q   <= 4'h0;
            oe_q    <= 1'b0;
        end else if (bus_stop) begin
            state_q <= ST_IDLE;
            oe_q    <= 1'b0;
        end else begin
            case (state_q)
                ST_RECV: begin
                    if (scl_rise && cnt_q != BYTE_BITS) begin
                        shift_q <= {shift_q[6:0], i_sda};
                        cnt_q   <= cnt_q + 4'h1;
                    end else if (byte_done) begin
                        if (kind_q == KIND_ADDR && !addr_hit) begin
                            // Someone else's transfer; stay silent
                            state_q <= ST_IDLE;
                        end else begin
                            if (kind_q == KIND_ADDR) begin
                                read_q <= shift_q[0];
                            end
                            state_q <= ST_ACK;
                            oe_q    <= 1'b1;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (kind_q == KIND_ADDR && read_q) begin
                            // Read starts at the stored pointer
                            state_q <= ST_SEND;
                            tx_q    <= rd_data;
                            oe_q    <= ~rd_data[7];
                            cnt_q   <= 4'h1;
                        end else begin
                            state_q <= ST_RECV;
                            kind_q  <= (kind_q == KIND_ADDR) ? KIND_PTR : KIND_DATA;
                            oe_q    <= 1'b0;
                            cnt_q   <= 4'h0;
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_fall) begin
                        if (cnt_q == BYTE_BITS) begin
                            state_q <= ST_MACK;
                            oe_q    <= 1'b0;
                        end else begin
                            tx_q  <= {tx_q[6:0], 1'b0};
                            oe_q  <= ~tx_q[6];
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        mack_q <= ~i_sda;
                    end else if (scl_fall) begin
                        if (mack_q) begin
                            state_q <= ST_SEND;
                            tx_q    <= rd_data;
                            oe_q    <= ~rd_data[7];
                            cnt_q   <= 4'h1;
                        end else begin
                            // Not acknowledged: wait for stop
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    oe_q    <= 1'b0;
                end
            endcase
        end
    end

    // Pointer: loaded by pointer byte, advanced per data byte
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ptr_q <= 8'h00;
        end else if (byte_done && kind_q == KIND_PTR) begin
            ptr_q <= shift_q;
        end else if (wr_fire) begin
            ptr_q <= ptr_q + 8'h01;
        end else if (state_q == ST_ACK && scl_fall && kind_q == KIND_ADDR && read_q) begin
            ptr_q <= ptr_q + 8'h01;
        end else if (state_q == ST_MACK && scl_fall && mack_q) begin
            ptr_q <= ptr_q + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    // Interrupt enables, one per channel
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            irq_enable_q <= RST_OVERLOAD_IRQ_ENABLE_2;
        end else if (wr_fire && ptr_q == OFS_OVERLOAD_IRQ_ENABLE_2) begin
            irq_enable_q <= shift_q;
        end
    end

    // Charger control; reserved bit forced low
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ctrl0_q <= RST_CHARGER_CONTROL_0;
        end else if (wr_fire && ptr_q == OFS_CHARGER_CONTROL_0) begin
            ctrl0_q <= {1'b0, shift_q[6:0]};
        end
    end

    // Cold range setup fields
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ctrl1_q <= RST_CHARGER_CONTROL_1;
        end else if (wr_fire && ptr_q == OFS_CHARGER_CONTROL_1) begin
            ctrl1_q <= shift_q;
        end
    end

    // Decoded timeout, registered for a clean data output
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_fast_charge_hours <= timeout_hours(RST_CHARGER_CONTROL_0[4:2]);
        end else begin
            o_fast_charge_hours <= timeout_hours(ctrl0_q.fast_charge_timeout_sel);
        end
    end

    // ----------------------------------------------------------------
    // Overload event flags
    // ----------------------------------------------------------------
    overload_flag_bank #(
        .WIDTH (OVERLOAD_CHANNELS)
    ) u_flags (
        .i_clk      (i_clk),
        .i_reset    (i_reset),
        .i_overload ({i_switch_overload, i_buck3_overload}),
        .i_enable   (irq_enable_q),
        .i_clear    (i_irq_clear),
        .o_flags    (o_overload_flags),
        .o_irq_req  (o_overload_irq_req)
    );

    assign o_sda                 = 1'b0;
    assign o_sda_oe              = oe_q;
    assign o_overload_irq_enable = irq_enable_q;
    assign o_charger_control_0   = ctrl0_q;
    assign o_charger_control_1   = ctrl1_q;

endmodule

// ### pmu_regs_checker.sv
module pmu_regs_checker (
    input wire logic       i_clk,                 // System clock
    input wire logic       i_reset,               // Synchronous reset
    input wire logic [7:1] i_switch_overload,     // Switch overload levels
    input wire logic       i_buck3_overload,      // Buck overload level
    input wire logic       i_irq_clear,           // Interrupt clear
    input wire logic [7:0] o_overload_flags,      // Sticky flags
    input wire logic       o_overload_irq_req,    // Interrupt pulse
    input wire logic [7:0] o_overload_irq_enable, // Enable image
    input wire logic [7:0] o_charger_control_0,   // Control image
    input wire logic [7:0] o_charger_control_1,   // Cold range image
    input wire logic [3:0] o_fast_charge_hours    // Decoded timeout
);
    import pmu_regs_pkg::*;
    // ------------------------------------------------------------
    // Edge detect on the overload levels
    // ------------------------------------------------------------
    logic [7:0] level;   // Levels in flag order
    logic [7:0] level_q; // Levels one cycle back
    logic [7:0] rise;    // Fresh overloads
    logic       hit;     // Fresh overload on an enabled channel
    assign level = {i_switch_overload, i_buck3_overload};
    assign rise  = level & ~level_q;
    assign hit   = (rise & o_overload_irq_enable) != 8'h00;
    // Zero matches the design's reset
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            level_q <= 8'h00;
        end else begin
            level_q <= level;
        end
    end
    // Independent timeout decode
    function automatic logic [3:0] hours_of(input logic [2:0] c);
        return (c == 3'h7) ? 4'hA : {1'b0, c} + 4'h2;
    endfunction
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence enabled_rise;
        hit;
    endsequence
    sequence clear_only;
        i_irq_clear && (rise == 8'h00);
    endsequence
    enable_reset_a: assert property ($fell(i_reset) |-> o_overload_irq_enable == 8'h00)
        else $error("enables not reset");
    ctrl0_reset_a: assert property ($fell(i_reset) |-> o_charger_control_0 == 8'h02)
        else $error("control 0 not reset");
    ctrl1_reset_a: assert property ($fell(i_reset) |-> o_charger_control_1 == 8'h20)
        else $error("control 1 not reset");
    reserved_zero_a: assert property (o_charger_control_0[7] == 1'b0)
        else $error("reserved control bit set");
    hours_decode_a: assert property (!$past(i_reset) |->
        o_fast_charge_hours == hours_of($past(o_charger_control_0[4:2])))
        else $error("timeout decode wrong");
    irq_raise_a: assert property (enabled_rise |=> o_overload_irq_req)
        else $error("no request");
    irq_cause_a: assert property (o_overload_irq_req |-> $past(hit))
        else $error("request without cause");
    flag_set_a: assert property (rise != 8'h00 |=> (o_overload_flags & $past(rise)) == $past(rise))
        else $error("flag not set");
    flag_clear_a: assert property (clear_only |=> o_overload_flags == 8'h00)
        else $error("flags not cleared");
endmodule
bind pmu_irq_mask_charger_ctrl_regs pmu_regs_checker u_pmu_regs_checker (
    .i_clk, .i_reset, .i_switch_overload, .i_buck3_overload, .i_irq_clear,
    .o_overload_flags, .o_overload_irq_req, .o_overload_irq_enable,
    .o_charger_control_0, .o_charger_control_1, .o_fast_charge_hours);

// ### i2c_host_model.sv
module i2c_host_model (
    input  wire logic i_clk,      // Bench clock
    input  wire logic i_sda,      // Resolved data wire
    output logic      o_scl,      // Clock to the target
    output logic      o_sda_pull  // High pulls data low
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus: clock high, data released
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    // Four-cycle phases double the target's margins
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // Data set while the clock is low, then clock raised
    task automatic rise_with(input logic b);
        tick(2);
        o_sda_pull <= ~b;
        tick(2);
        o_scl <= 1'b1;
        tick(4);
    endtask
    task automatic send_bit(input logic b);
        rise_with(b);
        o_scl <= 1'b0;
    endtask
    // Bit in, sampled mid high phase
    task automatic take_bit(output logic b);
        tick(2);
        o_sda_pull <= 1'b0;
        tick(2);
        o_scl <= 1'b1;
        tick(2);
        b = i_sda;
        tick(2);
        o_scl <= 1'b0;
    endtask
    // Start: data falls with the clock high
    task automatic start();
        rise_with(1'b1);
        o_sda_pull <= 1'b1;
        tick(4);
        o_scl <= 1'b0;
    endtask
    // Stop: data rises with the clock high
    task automatic stop();
        rise_with(1'b0);
        o_sda_pull <= 1'b0;
        tick(4);
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            send_bit(d[i]);
        end
        take_bit(b);
        ack = ~b;
    endtask
    // Last byte of a read gets a not-acknowledge
    task automatic get_byte(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) begin
            take_bit(d[i]);
        end
        send_bit(last);
    endtask
endmodule

// ### test_pmu_irq_mask_charger_ctrl_regs.sv
module test_pmu_irq_mask_charger_ctrl_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import pmu_regs_pkg::*;
    localparam logic [6:0] TARGET = 7'h2A; // Arbitrary bus address
    typedef struct {
        logic [7:0] ofs; // Offset
        logic [7:0] wr;  // Byte written
        logic [7:0] exp; // Expected image
        logic [3:0] hrs; // Expected timeout hours
    } row_t;
    logic       clk;        // System clock
    logic       reset;      // Synchronous reset
    logic [6:0] switch_ovl; // Switch overload levels
    logic       buck3_ovl;  // Buck overload level
    logic       irq_clear;  // Interrupt clear
    logic       scl;        // Host clock
    logic       sda_pull;   // Host pulls data low
    wire        sda;        // Resolved data wire
    logic       sda_drv;    // Target drive value
    logic       sda_oe;     // Target pulls data
    logic [7:0] flags;      // Sticky flags
    logic       irq_req;    // Interrupt pulse
    logic [7:0] irq_en;     // Enable image
    logic [7:0] ctrl0;      // Control image
    logic [7:0] ctrl1;      // Cold range image
    logic [3:0] hours;      // Decoded timeout
    logic [7:0] irq_count = 8'h00; // Requests seen
    logic [7:0] got;        // Read data
    int         failures = 0;
    int         compares = 0;
    row_t rows [13] = '{
        '{8'h04, 8'h80, 8'h00, 4'h2}, '{8'h04, 8'h45, 8'h45, 4'h3},
        '{8'h04, 8'h2A, 8'h2A, 4'h4}, '{8'h04, 8'hCF, 8'h4F, 4'h5},
        '{8'h04, 8'h10, 8'h10, 4'h6}, '{8'h04, 8'h76, 8'h76, 4'h7},
        '{8'h04, 8'h19, 8'h19, 4'h8}, '{8'h04, 8'hFF, 8'h7F, 4'hA},
        '{8'h03, 8'hA5, 8'hA5, 4'hA}, '{8'h03, 8'h5A, 8'h5A, 4'hA},
        '{8'h05, 8'hE3, 8'hE3, 4'hA}, '{8'h05, 8'h1C, 8'h1C, 4'hA},
        '{8'h07, 8'h99, 8'h00, 4'hA}};
    pmu_irq_mask_charger_ctrl_regs #(.TARGET_ADDR(TARGET)) u_pmu_irq_mask_charger_ctrl_regs (
        .i_clk(clk), .i_reset(reset), .i_scl(scl), .i_sda(sda), .o_sda(sda_drv),
        .o_sda_oe(sda_oe), .i_switch_overload(switch_ovl), .i_buck3_overload(buck3_ovl),
        .i_irq_clear(irq_clear), .o_overload_flags(flags), .o_overload_irq_req(irq_req),
        .o_overload_irq_enable(irq_en), .o_charger_control_0(ctrl0),
        .o_charger_control_1(ctrl1), .o_fast_charge_hours(hours));
    i2c_host_model u_i2c_host_model (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(sda_pull));
    // Open-drain wire with pull-up
    assign sda = (sda_oe ? sda_drv : 1'b1) & ~sda_pull;
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Count interrupt pulses
    always @(posedge clk) if (irq_req === 1'b1) irq_count <= irq_count + 8'h01;
    task automatic check8(input logic [7:0] g, input logic [7:0] e, input string what);
        compares++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic send(input logic [7:0] d, input logic want);
        logic a;
        u_i2c_host_model.put_byte(d, a);
        check8({7'h00, a}, {7'h00, want}, "acknowledge");
    endtask
    task automatic bus_write(input logic [7:0] ofs, input logic [7:0] d);
        u_i2c_host_model.start();
        send({TARGET, 1'b0}, 1'b1);
        send(ofs, 1'b1);
        send(d, 1'b1);
        u_i2c_host_model.stop();
    endtask
    // Pointer, restart, one byte back
    task automatic bus_read(input logic [7:0] ofs, output logic [7:0] d);
        u_i2c_host_model.start();
        send({TARGET, 1'b0}, 1'b1);
        send(ofs, 1'b1);
        u_i2c_host_model.start();
        send({TARGET, 1'b1}, 1'b1);
        u_i2c_host_model.get_byte(d, 1'b1);
        u_i2c_host_model.stop();
    endtask
    function automatic logic [7:0] image(input logic [7:0] ofs);
        case (ofs)
            OFS_OVERLOAD_IRQ_ENABLE_2: return irq_en;
            OFS_CHARGER_CONTROL_0:     return ctrl0;
            OFS_CHARGER_CONTROL_1:     return ctrl1;
            default:                   return 8'h00;
        endcase
    endfunction
    // Hang guard
    initial begin
        repeat (80000) @(posedge clk);
        failures++;
        finish_test();
    end
    initial begin
        reset = 1'b1;
        switch_ovl = 7'h00;
        buck3_ovl = 1'b0;
        irq_clear = 1'b0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        foreach (rows[n]) begin
            bus_write(rows[n].ofs, rows[n].wr);
            settle(2);
            check8(image(rows[n].ofs), rows[n].exp, "image");
            bus_read(rows[n].ofs, got);
            check8(got, rows[n].exp, "read back");
            check8({4'h0, hours}, {4'h0, rows[n].hrs}, "hours");
        end
        // Burst write, then read past block
        u_i2c_host_model.start();
        send({TARGET, 1'b0}, 1'b1);
        send(8'h03, 1'b1);
        send(8'h81, 1'b1);
        send(8'hC6, 1'b1);
        send(8'h6D, 1'b1);
        u_i2c_host_model.start();
        send({TARGET, 1'b1}, 1'b1);
        u_i2c_host_model.get_byte(got, 1'b1);
        check8(got, 8'h00, "pointer past block");
        u_i2c_host_model.stop();
        bus_read(8'h03, got);
        check8(got, 8'h81, "burst 03");
        bus_read(8'h04, got);
        check8(got, 8'h46, "burst 04");
        bus_read(8'h05, got);
        check8(got, 8'h6D, "burst 05");
        // Foreign address ignored
        u_i2c_host_model.start();
        send({TARGET ^ 7'h01, 1'b0}, 1'b0);
        send(8'h03, 1'b0);
        send(8'h00, 1'b0);
        u_i2c_host_model.stop();
        check8(irq_en, 8'h81, "foreign write");
        // Overload events
        bus_write(8'h03, 8'h82);
        @(posedge clk);
        buck3_ovl <= 1'b1;
        settle(4);
        check8(flags, 8'h01, "masked flag");
        check8(irq_count, 8'h00, "masked request");
        @(posedge clk);
        switch_ovl <= 7'h40;
        settle(4);
        check8(flags, 8'h81, "switch7 flag");
        check8(irq_count, 8'h01, "switch7 request");
        @(posedge clk);
        switch_ovl <= 7'h41;
        irq_clear <= 1'b1;
        @(posedge clk);
        irq_clear <= 1'b0;
        settle(4);
        check8(flags, 8'h02, "clear with rise");
        check8(irq_count, 8'h02, "switch1 request");
        @(posedge clk);
        irq_clear <= 1'b1;
        @(posedge clk);
        irq_clear <= 1'b0;
        settle(2);
        check8(flags, 8'h00, "clear");
        bus_write(8'h03, 8'h01);
        @(posedge clk);
        buck3_ovl <= 1'b0;
        @(posedge clk);
        buck3_ovl <= 1'b1;
        settle(4);
        check8(irq_count, 8'h03, "buck3 request");
        @(posedge clk);
        buck3_ovl <= 1'b0;
        switch_ovl <= 7'h00;
        // Second reset in mid-run
        reset <= 1'b1;
        settle(8);
        check8(irq_en, 8'h00, "enable reset");
        check8(ctrl0, 8'h02, "control 0 reset");
        check8(ctrl1, 8'h20, "control 1 reset");
        check8({4'h0, hours}, 8'h02, "hours reset");
        @(posedge clk);
        reset <= 1'b0;
        bus_read(8'h04, got);
        check8(got, 8'h02, "control 0 read");
        finish_test();
    end
endmodule
